// ---- logic/ptg_cfg.svh ----
// constants of the profile/timer generator bank
// assumes inclusion by bare name from package and modules
`ifndef PTG_CFG_SVH
`define PTG_CFG_SVH
// sizes
`define PTG_NGEN      8
`define PTG_NSEC      8
`define PTG_NCH       60
`define PTG_VW        16
`define PTG_AW        12
`define PTG_DW        32
// timing: 0.1 s tick from a 125 MHz clock
`define PTG_CLK_NS    8
`define PTG_TICK_NS   100000000
`define PTG_TK_SEC    32'd10
`define PTG_TK_MIN    32'd600
`define PTG_TK_HOUR   32'd36000
// address split: generator number above, register offset below
`define PTG_GEN_HI    10
`define PTG_GEN_LO    8
`define PTG_OFF_HI    7
// register offsets inside one generator
`define PTG_R_CTRL    8'h00
`define PTG_R_IDLE    8'h04
`define PTG_R_LCNT    8'h08
`define PTG_R_NSEC    8'h0c
`define PTG_R_STAT    8'h10
`define PTG_R_OUTV    8'h14
`define PTG_R_SEC     8'h40
`define PTG_SEC_HI    5
`define PTG_SEC_LO    3
`define PTG_SEC_WORD  2
`define PTG_SEC_MASK  8'hc0
// reset values
`define PTG_RST_V     16'h0000
`define PTG_RST_N     4'h0
`define PTG_RST_W     32'h0000_0000
`endif

// ---- logic/ptg_pkg.sv ----
// types of the profile/timer generator bank
// assumes ptg_cfg.svh on the include path
`include "ptg_cfg.svh"
package ptg_pkg;
    typedef enum logic [2:0] {
        PTG_TRG_OFF   = 3'h0,
        PTG_TRG_LEVEL = 3'h1,
        PTG_TRG_ONCE  = 3'h2,
        PTG_TRG_RETRG = 3'h3,
        PTG_TRG_TIME  = 3'h4
    } ptg_trg_t;
    typedef enum logic [1:0] {
        PTG_LOOP_OFF = 2'h0, PTG_LOOP_CNT = 2'h1, PTG_LOOP_CH = 2'h2, PTG_LOOP_INF = 2'h3
    } ptg_loop_t;
    typedef enum logic [1:0] {PTG_U_SEC = 2'h0, PTG_U_MIN = 2'h1, PTG_U_HOUR = 2'h2} ptg_unit_t;
    typedef enum logic [1:0] {PTG_ST_IDLE = 2'b01, PTG_ST_RUN = 2'b10} ptg_st_t;
    // control word, lsb last
    typedef struct packed {
        logic [5:0] lsrc;
        logic [5:0] tsrc;
        logic       sched;
        logic [2:0] ret;
        ptg_loop_t  loop;
        ptg_trg_t   mode;
    } ptg_ctrl_t;
    // section timing word, lsb last
    typedef struct packed {
        logic       slope;
        ptg_unit_t  unit;
        logic [15:0] dur;
    } ptg_secd_t;
    typedef struct packed {
        logic [15:0] loops;
        logic [11:0] pad;
        logic [2:0]  idx;
        logic        run;
    } ptg_stat_t;
    typedef struct packed {
        logic [`PTG_AW-1:0] addr;
        logic [`PTG_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } ptg_bus_t;
    typedef logic [`PTG_NCH-1:0][`PTG_VW-1:0]  ptg_chans_t;
    typedef logic [`PTG_NGEN-1:0][`PTG_VW-1:0] ptg_outs_t;
    typedef logic [`PTG_NGEN-1:0]              ptg_genv_t;
endpackage

// ---- logic/ptg_tick.sv ----
// time-base tick: one-cycle pulse every TICK_CYC clocks
// assumes a single clock with synchronous active-low reset
`timescale 1ns/1ns
`include "ptg_cfg.svh"
module ptg_tick #(
    parameter int unsigned TICK_CYC = 12500000
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic resetn_in,
    // tick
    output logic      tick_out
);
    logic [31:0] cnt;

    // free-running divider
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cnt      <= `PTG_RST_W;
            tick_out <= 1'b0;
        end else if (cnt >= TICK_CYC - 1) begin
            cnt      <= `PTG_RST_W;
            tick_out <= 1'b1;
        end else begin
            cnt      <= cnt + 32'd1;
            tick_out <= 1'b0;
        end
    end
endmodule

// ---- logic/ptg_top.sv ----
// bank of eight profile/timer setpoint generators with register port
// assumes channel values and schedule hits come from logic on sys_clk_in
//
// Contract
// R1: eight independent generators, each fully configured
// R2: trigger mode has five choices
// R3: level mode runs only while source above zero
// R4: single edge starts, profile runs to completion
// R5: every rising edge restarts from beginning
// R6: scheduled mode starts on configured time hits
// R7: trigger source picked from sixty channels
// R8: idle value output whenever not running
// R9: section: duration, unit, shape, final value
// R10: ramp linear from previous final over duration
// R11: constant section reached within 0.1 seconds
// R12: looping off runs list once
// R13: counted looping repeats loop count times
// R14: channel looping takes count from channel
// R15: infinite looping repeats without end
// R16: repeats restart at return position
// R17: no time option selected never starts
// R18: scheduled start runs to completion
// R19: durations counted in time-base ticks
// R20: disabled mode holds idle, ignores triggers
`timescale 1ns/1ns
`include "ptg_cfg.svh"
module ptg_top #(
    parameter int unsigned TICK_CYC = `PTG_TICK_NS / `PTG_CLK_NS
) (
    // clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                resetn_in,
    // register port
    input  wire ptg_pkg::ptg_bus_t   bus_in,
    output logic [`PTG_DW-1:0]       rdata_out,
    // logical channels and calendar hits
    input  wire ptg_pkg::ptg_chans_t chan_vals_in,
    input  wire ptg_pkg::ptg_genv_t  sched_hit_in,
    // generator outputs
    output ptg_pkg::ptg_outs_t       prof_out,
    output ptg_pkg::ptg_genv_t       running_out
);
    import ptg_pkg::*;

    // configuration store
    ptg_ctrl_t          ctrl   [`PTG_NGEN];
    logic [`PTG_VW-1:0] idle_v [`PTG_NGEN];
    logic [`PTG_VW-1:0] lcnt   [`PTG_NGEN];
    logic [3:0]         nsec   [`PTG_NGEN];
    ptg_secd_t          sec_d  [`PTG_NGEN][`PTG_NSEC];
    logic [`PTG_VW-1:0] sec_f  [`PTG_NGEN][`PTG_NSEC];

    // run state
    ptg_st_t            st     [`PTG_NGEN];
    logic [2:0]         idx    [`PTG_NGEN];
    logic [31:0]        elap   [`PTG_NGEN];
    logic [31:0]        total  [`PTG_NGEN];
    logic [`PTG_VW-1:0] start_v[`PTG_NGEN];
    logic [`PTG_VW-1:0] loops  [`PTG_NGEN];
    logic [`PTG_VW-1:0] outv   [`PTG_NGEN];
    logic               prev_pos[`PTG_NGEN];
    logic               armed  [`PTG_NGEN];
    logic               done   [`PTG_NGEN];

    logic               tick;
    logic [2:0]         bus_gen;
    logic [7:0]         bus_off;

    // section length in ticks for its unit
    function automatic logic [31:0] ticks_of(input ptg_secd_t d);
        logic [31:0] m;
        unique case (d.unit)
            PTG_U_MIN:  m = `PTG_TK_MIN;
            PTG_U_HOUR: m = `PTG_TK_HOUR;
            default:    m = `PTG_TK_SEC;
        endcase
        ticks_of = {16'h0000, d.dur} * m;
    endfunction

    // linear point after e ticks of t from s to f
    function automatic logic [`PTG_VW-1:0] ramp_val(input logic [15:0] s, input logic [15:0] f,
                                                   input logic [31:0] e, input logic [31:0] t);
        logic signed [16:0] d;
        logic signed [49:0] p;
        logic signed [49:0] q;
        d = $signed({f[15], f}) - $signed({s[15], s});
        p = d * $signed({1'b0, e});
        q = p / $signed({18'h00000, t});
        ramp_val = s + q[15:0];
    endfunction

    // offset falls in the section window
    function automatic logic is_sec(input logic [7:0] off);
        is_sec = (off & `PTG_SEC_MASK) == `PTG_R_SEC;
    endfunction

    // channel value as a signed count, clamped to at least one
    function automatic logic [15:0] at_least_one(input logic [15:0] v);
        at_least_one = ($signed(v) > 0) ? v : 16'h0001;
    endfunction

    assign bus_gen = bus_in.addr[`PTG_GEN_HI:`PTG_GEN_LO];
    assign bus_off = bus_in.addr[`PTG_OFF_HI:0];

    ptg_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .tick_out   (tick)
    );

    // configuration writes
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            for (int g = 0; g < `PTG_NGEN; g++) begin
                ctrl[g]   <= ptg_ctrl_t'(`PTG_RST_W);
                idle_v[g] <= `PTG_RST_V;
                lcnt[g]   <= `PTG_RST_V;
                nsec[g]   <= `PTG_RST_N;
                for (int s = 0; s < `PTG_NSEC; s++) begin
                    sec_d[g][s] <= ptg_secd_t'(`PTG_RST_W);
                    sec_f[g][s] <= `PTG_RST_V;
                end
            end
        end else if (bus_in.wr) begin
            if (is_sec(bus_off)) begin
                if (bus_off[`PTG_SEC_WORD])
                    sec_f[bus_gen][bus_off[`PTG_SEC_HI:`PTG_SEC_LO]] <= bus_in.wdata[`PTG_VW-1:0];
                else
                    sec_d[bus_gen][bus_off[`PTG_SEC_HI:`PTG_SEC_LO]] <=
                        ptg_secd_t'(bus_in.wdata[$bits(ptg_secd_t)-1:0]);  // [R9]
            end else begin
                unique case (bus_off)
                    `PTG_R_CTRL: ctrl[bus_gen] <= ptg_ctrl_t'(bus_in.wdata[$bits(ptg_ctrl_t)-1:0]);
                    `PTG_R_IDLE: idle_v[bus_gen] <= bus_in.wdata[`PTG_VW-1:0];
                    `PTG_R_LCNT: lcnt[bus_gen] <= bus_in.wdata[`PTG_VW-1:0];
                    // adding or removing sections: list length, capped
                    `PTG_R_NSEC: nsec[bus_gen] <= (bus_in.wdata[3:0] > 4'(`PTG_NSEC)) ?
                                                  4'(`PTG_NSEC) : bus_in.wdata[3:0];  // [R9]
                    default: ;
                endcase
            end
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_out <= `PTG_RST_W;
        end else if (bus_in.rd) begin
            if (is_sec(bus_off)) begin
                if (bus_off[`PTG_SEC_WORD])
                    rdata_out <= {16'h0000, sec_f[bus_gen][bus_off[`PTG_SEC_HI:`PTG_SEC_LO]]};
                else
                    rdata_out <= 32'(sec_d[bus_gen][bus_off[`PTG_SEC_HI:`PTG_SEC_LO]]);
            end else begin
                unique case (bus_off)
                    `PTG_R_CTRL: rdata_out <= 32'(ctrl[bus_gen]);
                    `PTG_R_IDLE: rdata_out <= {16'h0000, idle_v[bus_gen]};
                    `PTG_R_LCNT: rdata_out <= {16'h0000, lcnt[bus_gen]};
                    `PTG_R_NSEC: rdata_out <= {28'h0000000, nsec[bus_gen]};
                    `PTG_R_STAT: rdata_out <= ptg_stat_t'({loops[bus_gen], 12'h000, idx[bus_gen],
                                                           st[bus_gen] == PTG_ST_RUN});
                    `PTG_R_OUTV: rdata_out <= {16'h0000, outv[bus_gen]};
                    default:     rdata_out <= `PTG_RST_W;
                endcase
            end
        end else begin
            rdata_out <= `PTG_RST_W;
        end
    end

    // one independent engine per generator
    for (genvar g = 0; g < `PTG_NGEN; g++) begin : gen_eng  // [R1]
        logic [15:0] src;
        logic [15:0] lsrc_v;
        logic        pos;
        logic        rise;
        logic        go;
        logic        stop;
        logic        last_sec;
        logic        more;
        logic [2:0]  ret_idx;
        logic [2:0]  nxt_idx;
        logic [15:0] first_loops;

        // trigger and loop sources; out-of-range channels read zero
        assign src    = (ctrl[g].tsrc < 6'(`PTG_NCH)) ? chan_vals_in[ctrl[g].tsrc] : `PTG_RST_V;  // [R7]
        assign lsrc_v = (ctrl[g].lsrc < 6'(`PTG_NCH)) ? chan_vals_in[ctrl[g].lsrc] : `PTG_RST_V;
        assign pos    = $signed(src) > 0;
        assign rise   = pos && !prev_pos[g];

        // start decision per trigger mode
        always_comb begin
            unique case (ctrl[g].mode)  // [R2]
                PTG_TRG_LEVEL: go = pos && armed[g] && st[g] == PTG_ST_IDLE;  // [R3]
                PTG_TRG_ONCE:  go = rise && st[g] == PTG_ST_IDLE;              // [R4]
                PTG_TRG_RETRG: go = rise;                                       // [R5]
                PTG_TRG_TIME:  go = sched_hit_in[g] && ctrl[g].sched && st[g] == PTG_ST_IDLE;  // [R6] [R17] [R18]
                default:       go = 1'b0;                                       // [R20]
            endcase
            go = go && nsec[g] != `PTG_RST_N;
        end

        // level gate drops, or generator disabled
        assign stop = (ctrl[g].mode == PTG_TRG_LEVEL && !pos) ||
                      (ctrl[g].mode != PTG_TRG_LEVEL && ctrl[g].mode != PTG_TRG_ONCE &&
                       ctrl[g].mode != PTG_TRG_RETRG && ctrl[g].mode != PTG_TRG_TIME);  // [R3] [R20]

        // end of pass and where a repeat resumes
        assign last_sec = {1'b0, idx[g]} + 4'h1 >= nsec[g];
        assign more     = ctrl[g].loop == PTG_LOOP_INF || loops[g] > 16'h0001;  // [R15]
        assign ret_idx  = ({1'b0, ctrl[g].ret} < nsec[g]) ? ctrl[g].ret : 3'h0;  // [R16]
        assign nxt_idx  = last_sec ? ret_idx : idx[g] + 3'h1;

        // number of passes taken at start
        always_comb begin
            unique case (ctrl[g].loop)
                PTG_LOOP_CNT: first_loops = (lcnt[g] == `PTG_RST_V) ? 16'h0001 : lcnt[g];  // [R13]
                PTG_LOOP_CH:  first_loops = at_least_one(lsrc_v);                          // [R14]
                default:      first_loops = 16'h0001;                                      // [R12]
            endcase
        end

        // edge history and level re-arm
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                prev_pos[g] <= 1'b1;
                armed[g]    <= 1'b0;
            end else begin
                prev_pos[g] <= pos;
                if (!pos)
                    armed[g] <= 1'b1;
                else if (go)
                    armed[g] <= 1'b0;
            end
        end

        // sequencer and output value
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                st[g]      <= PTG_ST_IDLE;
                idx[g]     <= 3'h0;
                elap[g]    <= `PTG_RST_W;
                total[g]   <= `PTG_RST_W;
                start_v[g] <= `PTG_RST_V;
                loops[g]   <= `PTG_RST_V;
                outv[g]    <= `PTG_RST_V;
                done[g]    <= 1'b0;
            end else if (go) begin
                // fresh start or restart from the first section
                st[g]      <= PTG_ST_RUN;
                idx[g]     <= 3'h0;
                elap[g]    <= `PTG_RST_W;
                total[g]   <= ticks_of(sec_d[g][0]);
                start_v[g] <= outv[g];
                loops[g]   <= first_loops;
                done[g]    <= 1'b0;
            end else if (st[g] == PTG_ST_IDLE || stop || done[g]) begin
                // running and idle value change together, never final value while stopped
                st[g]   <= PTG_ST_IDLE;
                outv[g] <= idle_v[g];  // [R8] [R20]
                done[g] <= 1'b0;
            end else if (tick) begin  // [R19]
                if (elap[g] + 32'd1 >= total[g]) begin
                    // section done: land exactly on its final value
                    outv[g]    <= sec_f[g][idx[g]];
                    start_v[g] <= sec_f[g][idx[g]];
                    elap[g]    <= `PTG_RST_W;
                    total[g]   <= ticks_of(sec_d[g][nxt_idx]);
                    if (last_sec && !more) begin
                        done[g] <= 1'b1;  // [R12] final value shown one cycle while still running
                    end else begin
                        idx[g] <= nxt_idx;  // [R16]
                        if (last_sec && ctrl[g].loop != PTG_LOOP_INF)
                            loops[g] <= loops[g] - 16'h0001;  // [R13] [R14]
                    end
                end else begin
                    elap[g] <= elap[g] + 32'd1;
                    if (sec_d[g][idx[g]].slope)
                        outv[g] <= ramp_val(start_v[g], sec_f[g][idx[g]], elap[g] + 32'd1, total[g]);  // [R10]
                    else
                        outv[g] <= sec_f[g][idx[g]];  // [R11]
                end
            end
        end

        assign prof_out[g]    = outv[g];
        assign running_out[g] = st[g] == PTG_ST_RUN;
    end
endmodule

// ---- bench/ptg_chan_model.sv ----
// logical channel model: sources triggers and loop counts
// assumes calls come from one bench thread, outputs change on rising edges
`timescale 1ns/1ns
module ptg_chan_model (
    // clock
    input  wire logic           sys_clk_in,
    // channel values and calendar hits
    output ptg_pkg::ptg_chans_t chans_out,
    output ptg_pkg::ptg_genv_t  hits_out
);
    import ptg_pkg::*;
    // all channels start at zero, no calendar match
    initial begin
        chans_out = '0;
        hits_out = '0;
    end
    // one channel takes a new value at an edge
    task automatic set_ch(input int n, input logic [15:0] v);
        @(posedge sys_clk_in);
        chans_out[n] <= v;
    endtask
    // one-cycle calendar match for one generator
    task automatic hit(input int g);
        @(posedge sys_clk_in);
        hits_out[g] <= 1'b1;
        @(posedge sys_clk_in);
        hits_out[g] <= 1'b0;
    endtask
endmodule

// ---- bench/ptg_top_chk.sv ----
// checker on the generator bank ports, bound into ptg_top
// assumes control writes shadowed here match the register map
`timescale 1ns/1ns
`include "ptg_cfg.svh"
module ptg_top_chk #(
    parameter int unsigned TICK_CYC = 4
) (
    // clock and reset
    input wire logic                sys_clk_in,
    input wire logic                resetn_in,
    // register port
    input wire ptg_pkg::ptg_bus_t   bus_in,
    input wire logic [`PTG_DW-1:0]  rdata_out,
    // channels and outputs
    input wire ptg_pkg::ptg_chans_t chan_vals_in,
    input wire ptg_pkg::ptg_genv_t  sched_hit_in,
    input wire ptg_pkg::ptg_outs_t  prof_out,
    input wire ptg_pkg::ptg_genv_t  running_out
);
    import ptg_pkg::*;
    ptg_ctrl_t   ctl [`PTG_NGEN];
    ptg_genv_t   has_sec;
    logic [31:0] wd_q;
    logic [11:0] wa_q;
    wire  [7:0]  off = bus_in.addr[7:0];
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // shadow of control and section-count writes
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctl <= '{default: '0};
            has_sec <= '0;
        end else if (bus_in.wr && off == `PTG_R_CTRL) begin
            ctl[bus_in.addr[10:8]] <= ptg_ctrl_t'(bus_in.wdata[20:0]);
        end else if (bus_in.wr && off == `PTG_R_NSEC) begin
            has_sec[bus_in.addr[10:8]] <= bus_in.wdata[3:0] != 4'h0;
        end
    end
    // last write address and data
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            wa_q <= '0;
            wd_q <= '0;
        end else if (bus_in.wr) begin
            wa_q <= bus_in.addr;
            wd_q <= bus_in.wdata;
        end
    end
    a_read_stands: assert property (
        !$past(bus_in.rd) |-> rdata_out == '0) else $error("read data outside read cycle");
    a_reg_readback: assert property (
        bus_in.rd && bus_in.addr == wa_q && wa_q[7:0] inside {`PTG_R_IDLE, `PTG_R_LCNT}
        |=> rdata_out == {16'h0, wd_q[15:0]}) else $error("readback differs from write");
    a_unmapped_zero: assert property (
        bus_in.rd && off inside {[8'h18:8'h3f], [8'h80:8'hff]} |=> rdata_out == '0)
        else $error("unmapped read not zero");
    // per generator trigger and idle relations
    for (genvar g = 0; g < `PTG_NGEN; g++) begin : per_gen
        wire logic signed [15:0] src = ctl[g].tsrc < 6'h3c ? chan_vals_in[ctl[g].tsrc] : 16'sh0;
        wire ptg_trg_t m = ctl[g].mode;
        a_off_stops: assert property (m == PTG_TRG_OFF |=> !running_out[g])
            else $error("disabled generator running");
        a_level_gate: assert property (m == PTG_TRG_LEVEL && src <= 0 |=> !running_out[g])
            else $error("closed gate still running");
        a_edge_start: assert property (
            (m == PTG_TRG_RETRG || (m == PTG_TRG_ONCE && !running_out[g])) && has_sec[g]
            && src > 0 && $past(src) <= 0 |=> running_out[g]) else $error("rise did not start");
        a_time_start: assert property (
            m == PTG_TRG_TIME && ctl[g].sched && sched_hit_in[g] && has_sec[g] |=> running_out[g])
            else $error("schedule hit did not start");
        a_time_never: assert property (
            m == PTG_TRG_TIME && !ctl[g].sched && !running_out[g] |=> !running_out[g])
            else $error("unscheduled start");
        a_idle_hold: assert property (
            !running_out[g] && !$past(running_out[g]) && !$past(bus_in.wr) && !$past(bus_in.wr, 2)
            |-> $stable(prof_out[g])) else $error("idle output moved");
    end
    c_once_run: cover property ($rose(running_out[0]));
    c_time_run: cover property (ctl[4].sched && $rose(running_out[4]));
    c_gate_shut: cover property ($fell(running_out[2]));
endmodule
bind ptg_top ptg_top_chk #(.TICK_CYC(TICK_CYC)) chk (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .chan_vals_in(chan_vals_in), .sched_hit_in(sched_hit_in), .prof_out(prof_out), .running_out(running_out));

// ---- bench/tb_top.sv ----
// testbench: register-port tasks and channel model drive the bank
// assumes a short tick of 4 clocks, so one second is 40 clocks
`timescale 1ns/1ns
`include "ptg_cfg.svh"
module tb_top;
    import ptg_pkg::*;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    ptg_bus_t    bus = '0;
    logic [31:0] rdata;
    ptg_chans_t  chans;
    ptg_genv_t   hits;
    ptg_outs_t   prof;
    ptg_genv_t   run;
    logic [15:0] pv;
    logic [15:0] early;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n;
    int          nchg;
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    ptg_top #(.TICK_CYC(4)) dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .bus_in(bus), .rdata_out(rdata),
        .chan_vals_in(chans), .sched_hit_in(hits), .prof_out(prof), .running_out(run));
    ptg_chan_model chm (.sys_clk_in(sys_clk), .chans_out(chans), .hits_out(hits));
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] g, input logic [7:0] o, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= {1'b0, g, o, d, 2'b10};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [2:0] g, input logic [7:0] o, input logic [31:0] e);
        @(posedge sys_clk);
        bus <= {1'b0, g, o, 32'h0, 2'b01};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        check("rdata", rdata, e);
    endtask
    function automatic logic [31:0] mk(input logic [2:0] m, input logic [1:0] l, input logic [2:0] r,
                                       input logic s, input logic [5:0] t, input logic [5:0] c);
        return {11'h0, c, t, s, r, l, m};
    endfunction
    task automatic cfg(input logic [2:0] g, input logic [31:0] c, input logic [31:0] i, input logic [31:0] s);
        wr(g, `PTG_R_IDLE, i);
        wr(g, `PTG_R_NSEC, s);
        wr(g, `PTG_R_CTRL, c);
    endtask
    task automatic sec(input logic [2:0] g, input logic [2:0] s, input logic [31:0] t, input logic [31:0] f);
        wr(g, 8'h40 + {2'h0, s, 3'h0}, t);
        wr(g, 8'h44 + {2'h0, s, 3'h0}, f);
    endtask
    // run length, output steps and early value of one profile
    task automatic go(input int g, input int ch, input int t);
        if (ch < 0) chm.hit(g);
        else begin
            chm.set_ch(ch, 16'h0001);
            chm.set_ch(ch, 16'h0000);
        end
        n = 0;
        @(negedge sys_clk);
        while (run[g] !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        nchg = 0;
        pv = prof[g];
        while (run[g] === 1'b1 && n < 4 * t + 9) begin
            if (prof[g] !== pv) nchg++;
            pv = prof[g];
            if (n == 5) early = prof[g];
            @(negedge sys_clk);
            n++;
        end
        check("run length", {31'h0, n >= 4 * t - 4 && n <= 4 * t + 2}, 32'h1);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        close_out;
    end
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(0, `PTG_R_STAT, 32'h0);
        rd(0, `PTG_R_CTRL, 32'h0);
        wr(3, `PTG_R_IDLE, 32'hdead_1234);
        rd(3, `PTG_R_IDLE, 32'h0000_1234);
        wr(3, 8'h20, 32'h0000_0001);
        rd(3, 8'h20, 32'h0);
        wr(3, `PTG_R_NSEC, 32'h0000_0009);
        rd(3, `PTG_R_NSEC, 32'h0000_0008);
        check("idle out", {16'h0, prof[3]}, 32'h0000_1234);
        sec(0, 3'h0, 32'h0004_0001, 32'h0000_000a);
        cfg(0, mk(3'h2, 2'h0, 3'h0, 1'b0, 6'h01, 6'h00), 32'h0, 32'h1);
        go(0, 1, 10);
        check("ramp steps", nchg, 32'h0000_000a);
        check("ramp end", {16'h0, pv}, 32'h0000_000a);
        wr(0, `PTG_R_CTRL, mk(3'h3, 2'h0, 3'h0, 1'b0, 6'h01, 6'h00));
        chm.set_ch(1, 16'h0001);
        chm.set_ch(1, 16'h0000);
        repeat (20) @(posedge sys_clk);
        go(0, 1, 10);
        sec(1, 3'h0, 32'h0000_0001, 32'h0000_0007);
        sec(1, 3'h1, 32'h0004_0001, 32'h0000_0011);
        cfg(1, mk(3'h2, 2'h0, 3'h1, 1'b0, 6'h02, 6'h04), 32'h3, 32'h2);
        go(1, 2, 20);
        wr(1, `PTG_R_LCNT, 32'h3);
        wr(1, `PTG_R_CTRL, mk(3'h2, 2'h1, 3'h1, 1'b0, 6'h02, 6'h04));
        go(1, 2, 40);
        chm.set_ch(4, 16'h0002);
        wr(1, `PTG_R_CTRL, mk(3'h2, 2'h2, 3'h0, 1'b0, 6'h02, 6'h04));
        go(1, 2, 40);
        wr(1, `PTG_R_CTRL, mk(3'h2, 2'h3, 3'h0, 1'b0, 6'h02, 6'h04));
        chm.set_ch(2, 16'h0001);
        repeat (300) @(negedge sys_clk);
        check("endless run", {31'h0, run[1]}, 32'h1);
        wr(1, `PTG_R_CTRL, 32'h0);
        repeat (3) @(negedge sys_clk);
        check("off stops", {31'h0, run[1]}, 32'h0);
        check("idle after", {16'h0, prof[1]}, 32'h3);
        sec(2, 3'h0, 32'h0004_0002, 32'h0000_0014);
        cfg(2, mk(3'h1, 2'h0, 3'h0, 1'b0, 6'h03, 6'h00), 32'h2, 32'h1);
        chm.set_ch(3, 16'h0001);
        repeat (20) @(negedge sys_clk);
        check("gate open", {31'h0, run[2]}, 32'h1);
        chm.set_ch(3, 16'hffff);
        repeat (3) @(negedge sys_clk);
        check("gate shut", {31'h0, run[2]}, 32'h0);
        check("gate idle", {16'h0, prof[2]}, 32'h2);
        sec(4, 3'h0, 32'h0001_0001, 32'h0000_0007);
        cfg(4, mk(3'h4, 2'h0, 3'h0, 1'b0, 6'h00, 6'h00), 32'h0, 32'h1);
        chm.hit(4);
        repeat (4) @(negedge sys_clk);
        check("no schedule", {31'h0, run[4]}, 32'h0);
        wr(4, `PTG_R_CTRL, mk(3'h4, 2'h0, 3'h0, 1'b1, 6'h00, 6'h00));
        fork
            go(4, -1, 600);
            begin
                repeat (200) @(posedge sys_clk);
                chm.hit(4);
            end
        join
        check("const early", {16'h0, early}, 32'h7);
        check("spare gens", {run[7:5], prof[7][7:0], prof[5][7:0]}, 32'h0);
        close_out;
    end
endmodule
